// *** gpe_pkg.sv ***
// Shared constants of the gateway packet engine and its serial register port.
package gpe_pkg;
	localparam int BUF_BYTES = 1024;
	localparam int FIFO_DEPTH = 16;
	localparam int TRL_BYTES = 16;
	localparam int HDR_BYTES = 16;
	localparam int TX_MAX_PAY = 128;
	localparam int TXBUF_BYTES = HDR_BYTES + TX_MAX_PAY;
	localparam int CLK_PERIOD_NS = 10;
	localparam int TICK_NS = 1000;
	localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
	localparam int SCK_HALF = 4;
	localparam int BUF_W = 8;
	localparam int BUF_D = 2;
	localparam logic [6:0] A_PKT_DATA = 7'h00;
	localparam logic [6:0] A_TX_DATA = 7'h01;
	localparam logic [6:0] A_PTR_LO = 7'h02;
	localparam logic [6:0] A_PTR_HI = 7'h03;
	localparam logic [6:0] A_FIFO_CTRL = 7'h04;
	localparam logic [6:0] A_PKT_COUNT = 7'h05;
	localparam logic [6:0] A_ENT_START_LO = 7'h06;
	localparam logic [6:0] A_ENT_START_HI = 7'h07;
	localparam logic [6:0] A_ENT_LEN = 7'h08;
	localparam logic [6:0] A_TX_CTRL = 7'h09;
	localparam logic [6:0] A_TX_PTR = 7'h0A;
	localparam int NEXT_POS = 0;
	localparam int ARM_POS = 0;
	localparam int WAIT_POS = 0;
	localparam int SEND_POS = 1;
	localparam int H_FREQ = 0;
	localparam int H_TIME = 3;
	localparam int H_CTRL = 7;
	localparam int H_B9 = 9;
	localparam int H_LEN = 10;
	localparam int H_B11 = 11;
	localparam int H_PRE = 12;
	localparam int H_RATE = 14;
	localparam int RADIO_POS = 5;
	localparam int MOD_POS = 4;
	localparam int PWR_LSB = 0;
	localparam logic [3:0] PWR_HIGH_ABOVE = 4'h7;
	localparam int CRC_POS = 7;
	localparam int CR_LSB = 4;
	localparam int SF_LSB = 0;
	localparam int IMPL_POS = 2;
	localparam int BW_LSB = 0;
	localparam int VLEN_POS = 0;
	localparam int FCRC_POS = 1;
	localparam int DCF_LSB = 2;
	localparam int POLY_POS = 4;
	localparam logic [7:0] RST_BYTE = 8'h00;
endpackage

// *** gpe_link_if.sv ***
// Serial register link between the host and the packet engine.
`timescale 1ns/100ps
`default_nettype none
interface gpe_link_if;
	logic csn_n;
	logic sck;
	logic mosi;
	logic miso;
	modport device (input csn_n, input sck, input mosi, output miso);
	modport host (output csn_n, output sck, output mosi, input miso);
endinterface
`default_nettype wire

// *** gpe_device.sv ***
// Packet engine: receive buffer with access FIFO, transmit buffer and register port.
`timescale 1ns/100ps
`default_nettype none
module gpe_device (
	input wire logic ref_clk,
	input wire logic rst,
	gpe_link_if.device link,
	input wire logic rx_valid,
	output logic rx_ready,
	input wire logic [gpe_pkg::BUF_W-1:0] rx_data,
	input wire logic rx_last,
	input wire logic [7:0] rx_channel,
	input wire logic [3:0] rx_spreading_factor,
	input wire logic [2:0] rx_coding_rate_code,
	input wire logic rx_crc_en,
	input wire logic [7:0] rx_snr_avg,
	input wire logic [7:0] rx_snr_min,
	input wire logic [7:0] rx_snr_max,
	input wire logic [7:0] rx_rssi,
	input wire logic [15:0] rx_crc_value,
	input wire logic [7:0] rx_demod_unit_index,
	input wire logic [15:0] rx_corr_peak_position,
	input wire logic [7:0] rx_detect_corr_quality,
	output logic tx_start,
	output logic tx_valid,
	input wire logic tx_ready,
	output logic [7:0] tx_data,
	output logic tx_last,
	output logic tx_busy,
	output logic [23:0] tx_freq_code,
	output logic [31:0] tx_start_time,
	output logic tx_radio_b,
	output logic tx_fsk,
	output logic tx_power_high,
	output logic tx_crc_en,
	output logic [2:0] tx_coding_rate_code,
	output logic [3:0] tx_spreading_factor,
	output logic [7:0] tx_payload_len,
	output logic tx_implicit_hdr,
	output logic [1:0] tx_bandwidth,
	output logic [15:0] tx_preamble_len,
	output logic [7:0] tx_freq_dev,
	output logic tx_var_len,
	output logic tx_fsk_crc_en,
	output logic [1:0] tx_dc_free,
	output logic tx_check_polynomial_select,
	output logic [15:0] tx_bitrate_div,
	output logic [31:0] timer_us
);
	import gpe_pkg::*;
	typedef enum logic [3:0] {RX_IDLE = 4'b0001, RX_PAY = 4'b0010, RX_TRL = 4'b0100,
		RX_DROP = 4'b1000} gpe_rx_state_type;
	typedef enum logic [2:0] {TX_IDLE = 3'b001, TX_WAIT = 3'b010, TX_SEND = 3'b100} gpe_tx_state_type;
	gpe_rx_state_type rx_st_q;
	gpe_tx_state_type tx_st_q;
	logic [2:0] sck_q;
	logic [1:0] csn_q;
	logic [1:0] mosi_q;
	logic [2:0] bit_q;
	logic hdr_q;
	logic wnr_q;
	logic [6:0] addr_q;
	logic [7:0] sh_q;
	logic [7:0] out_q;
	logic miso_q;
	logic [9:0] ptr_q;
	logic next_q;
	logic arm_q;
	logic [7:0] tx_ptr_q;
	logic [7:0] rd_val;
	logic [7:0] rxbuf_q [BUF_BYTES];
	logic [7:0] txbuf_q [TXBUF_BYTES];
	logic [9:0] fs_q [FIFO_DEPTH];
	logic [7:0] fl_q [FIFO_DEPTH];
	logic [3:0] fw_q;
	logic [3:0] fr_q;
	logic [4:0] cnt_q;
	logic [9:0] pres_start_q;
	logic [7:0] pres_len_q;
	logic pres_v_q;
	logic [9:0] wr_ptr_q;
	logic [7:0] len_q;
	logic [3:0] tidx_q;
	logic [10:0] free_q;
	logic [127:0] meta_q;
	logic [6:0] pre_q;
	logic [31:0] timer_q;
	logic [7:0] idx_q;
	logic [7:0] tx_data_q;
	logic tx_start_q;

	// The link clock is only sampled, so both edges are found after the same two-stage delay.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sck_q <= 3'h0;
			csn_q <= 2'h3;
			mosi_q <= 2'h0;
		end else begin
			sck_q <= {sck_q[1:0], link.sck};
			csn_q <= {csn_q[0], link.csn_n};
			mosi_q <= {mosi_q[0], link.mosi};
		end
	end
	wire sel = ~csn_q[1];
	wire rise = sel & sck_q[1] & ~sck_q[2];
	wire fall = sel & ~sck_q[1] & sck_q[2];
	wire [7:0] byte_v = {sh_q[6:0], mosi_q[1]};
	wire byte_done = rise & (bit_q == 3'h7);
	wire data_done = byte_done & ~hdr_q;
	wire wr_en = data_done & wnr_q;
	wire fifo_addr = (addr_q == A_PKT_DATA) | (addr_q == A_TX_DATA);
	wire tx_idle = tx_st_q == TX_IDLE;
	wire tx_wr = wr_en & (addr_q == A_TX_DATA) & tx_idle & (tx_ptr_q < 8'(TXBUF_BYTES));

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			bit_q <= 3'h0;
			hdr_q <= 1'b1;
			wnr_q <= 1'b0;
			addr_q <= 7'h00;
			sh_q <= 8'h00;
			out_q <= 8'h00;
			miso_q <= 1'b0;
		end else if (!sel) begin
			bit_q <= 3'h0;
			hdr_q <= 1'b1;
			miso_q <= 1'b0;
		end else begin
			if (rise) begin
				sh_q <= byte_v;
				bit_q <= bit_q + 3'h1;
				if (byte_done && hdr_q) begin
					hdr_q <= 1'b0;
					wnr_q <= byte_v[7];
					addr_q <= byte_v[6:0];
				end else if (data_done && !fifo_addr) begin
					addr_q <= addr_q + 7'h01;
				end
			end
			// A write burst still shifts out the old register contents.
			if (fall && !hdr_q) begin
				if (bit_q == 3'h0) begin
					{miso_q, out_q} <= {rd_val, 1'b0};
				end else begin
					{miso_q, out_q} <= {out_q, 1'b0};
				end
			end
		end
	end
	assign link.miso = miso_q;

	always_comb begin
		unique case (addr_q)
			A_PKT_DATA: rd_val = rxbuf_q[ptr_q];
			A_PTR_LO: rd_val = ptr_q[7:0];
			A_PTR_HI: rd_val = {6'h00, ptr_q[9:8]};
			A_PKT_COUNT: rd_val = {3'h0, cnt_q};
			A_ENT_START_LO: rd_val = pres_start_q[7:0];
			A_ENT_START_HI: rd_val = {6'h00, pres_start_q[9:8]};
			A_ENT_LEN: rd_val = pres_len_q;
			A_TX_CTRL: rd_val = {6'h00, tx_st_q == TX_SEND, tx_st_q == TX_WAIT};
			A_TX_PTR: rd_val = tx_ptr_q;
			default: rd_val = 8'h00;
		endcase
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ptr_q <= 10'h000;
			tx_ptr_q <= 8'h00;
			next_q <= 1'b0;
			arm_q <= 1'b0;
		end else begin
			next_q <= wr_en & (addr_q == A_FIFO_CTRL) & byte_v[NEXT_POS];
			arm_q <= wr_en & (addr_q == A_TX_CTRL) & byte_v[ARM_POS] & tx_idle;
			if (wr_en && addr_q == A_PTR_LO) begin
				ptr_q[7:0] <= byte_v;
			end else if (wr_en && addr_q == A_PTR_HI) begin
				ptr_q[9:8] <= byte_v[1:0];
			end else if (data_done && !wnr_q && addr_q == A_PKT_DATA) begin
				ptr_q <= ptr_q + 10'h001;
			end
			if (wr_en && addr_q == A_TX_PTR) begin
				tx_ptr_q <= byte_v;
			end else if (tx_wr) begin
				tx_ptr_q <= tx_ptr_q + 8'h01;
			end
		end
	end

	// Receive side: payload streams into the ring, the trailer follows from captured metadata.
	wire fifo_full = cnt_q == 5'(FIFO_DEPTH);
	wire byte_ok = ~fifo_full & (len_q != 8'hFF) &
		(({3'h0, len_q} + 11'(TRL_BYTES + 1)) <= free_q);
	wire take = rx_valid & rx_ready;
	wire in_trl = rx_st_q == RX_TRL;
	wire storing = take & byte_ok & ((rx_st_q == RX_IDLE) | (rx_st_q == RX_PAY));
	wire [9:0] wa = wr_ptr_q + {2'h0, len_q} + (in_trl ? {6'h00, tidx_q} : 10'h000);
	wire [7:0] wd = in_trl ? meta_q[{tidx_q, 3'h0} +: 8] : rx_data;
	wire commit = in_trl & (tidx_q == 4'hF);
	wire pop = next_q & (cnt_q != 5'h00);
	wire [10:0] seg_len = {3'h0, len_q} + 11'(TRL_BYTES);
	wire [10:0] rel = (next_q & pres_v_q) ? {3'h0, pres_len_q} + 11'(TRL_BYTES) : 11'h000;
	wire [127:0] meta_in = {rx_detect_corr_quality, rx_corr_peak_position, rx_demod_unit_index,
		rx_crc_value, timer_q, rx_rssi, rx_snr_max, rx_snr_min, rx_snr_avg,
		rx_spreading_factor, rx_coding_rate_code, rx_crc_en, rx_channel};
	assign rx_ready = ~in_trl;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < BUF_BYTES; i++) begin
				rxbuf_q[i] <= RST_BYTE;
			end
		end else if (storing || in_trl) begin
			rxbuf_q[wa] <= wd;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rx_st_q <= RX_IDLE;
			len_q <= 8'h00;
			tidx_q <= 4'h0;
			wr_ptr_q <= 10'h000;
			meta_q <= 128'h0;
		end else begin
			unique case (rx_st_q)
				RX_IDLE, RX_PAY: begin
					if (take && !byte_ok) begin
						len_q <= 8'h00;
						rx_st_q <= rx_last ? RX_IDLE : RX_DROP;
					end else if (take) begin
						len_q <= len_q + 8'h01;
						rx_st_q <= rx_last ? RX_TRL : RX_PAY;
						if (rx_last) begin
							meta_q <= meta_in;
						end
					end
				end
				RX_TRL: begin
					tidx_q <= tidx_q + 4'h1;
					if (commit) begin
						rx_st_q <= RX_IDLE;
						len_q <= 8'h00;
						wr_ptr_q <= wr_ptr_q + seg_len[9:0];
					end
				end
				RX_DROP: if (take && rx_last) begin
					rx_st_q <= RX_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			fw_q <= 4'h0;
			fr_q <= 4'h0;
			cnt_q <= 5'h00;
			pres_start_q <= 10'h000;
			pres_len_q <= 8'h00;
			pres_v_q <= 1'b0;
			free_q <= 11'(BUF_BYTES);
		end else begin
			free_q <= free_q + rel - (commit ? seg_len : 11'h000);
			cnt_q <= cnt_q + {4'h0, commit} - {4'h0, pop};
			if (commit) begin
				fs_q[fw_q] <= wr_ptr_q;
				fl_q[fw_q] <= len_q;
				fw_q <= fw_q + 4'h1;
			end
			if (next_q) begin
				pres_v_q <= pop;
			end
			if (pop) begin
				pres_start_q <= fs_q[fr_q];
				pres_len_q <= fl_q[fr_q];
				fr_q <= fr_q + 4'h1;
			end
		end
	end

	// One microsecond timer stamps received packets and times departures.
	wire tick = pre_q == 7'(TICK_CYCLES - 1);
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pre_q <= 7'h00;
			timer_q <= 32'h0;
		end else begin
			pre_q <= tick ? 7'h00 : pre_q + 7'h01;
			if (tick) begin
				timer_q <= timer_q + 32'h1;
			end
		end
	end
	assign timer_us = timer_q;

	// Header fields, most significant byte first.
	wire [7:0] b7 = txbuf_q[H_CTRL];
	wire [7:0] b9 = txbuf_q[H_B9];
	wire [7:0] b11 = txbuf_q[H_B11];
	wire [7:0] plen = txbuf_q[H_LEN];
	wire [7:0] eff_len = (plen > 8'(TX_MAX_PAY)) ? 8'(TX_MAX_PAY) : plen;
	wire [7:0] last_idx = 8'(HDR_BYTES) + eff_len - 8'h01;
	assign tx_freq_code = {txbuf_q[H_FREQ], txbuf_q[H_FREQ+1], txbuf_q[H_FREQ+2]};
	assign tx_start_time = {txbuf_q[H_TIME], txbuf_q[H_TIME+1], txbuf_q[H_TIME+2],
		txbuf_q[H_TIME+3]};
	assign tx_radio_b = b7[RADIO_POS];
	assign tx_fsk = b7[MOD_POS];
	assign tx_power_high = b7[PWR_LSB +: 4] > PWR_HIGH_ABOVE;
	assign tx_crc_en = ~tx_fsk & b9[CRC_POS];
	assign tx_coding_rate_code = tx_fsk ? 3'h0 : b9[CR_LSB +: 3];
	assign tx_spreading_factor = tx_fsk ? 4'h0 : b9[SF_LSB +: 4];
	assign tx_payload_len = plen;
	assign tx_implicit_hdr = ~tx_fsk & b11[IMPL_POS];
	assign tx_bandwidth = tx_fsk ? 2'h0 : b11[BW_LSB +: 2];
	assign tx_preamble_len = {txbuf_q[H_PRE], txbuf_q[H_PRE+1]};
	assign tx_freq_dev = tx_fsk ? b9 : 8'h00;
	assign tx_var_len = tx_fsk & b11[VLEN_POS];
	assign tx_fsk_crc_en = tx_fsk & b11[FCRC_POS];
	assign tx_dc_free = tx_fsk ? b11[DCF_LSB +: 2] : 2'h0;
	assign tx_check_polynomial_select = tx_fsk & b11[POLY_POS];
	assign tx_bitrate_div = tx_fsk ? {txbuf_q[H_RATE], txbuf_q[H_RATE+1]} : 16'h0000;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < TXBUF_BYTES; i++) begin
				txbuf_q[i] <= RST_BYTE;
			end
		end else if (tx_wr) begin
			txbuf_q[tx_ptr_q] <= byte_v;
		end
	end

	wire due = (tx_st_q == TX_WAIT) & (timer_q == tx_start_time);
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			tx_st_q <= TX_IDLE;
			idx_q <= 8'h00;
			tx_data_q <= 8'h00;
			tx_start_q <= 1'b0;
		end else begin
			tx_start_q <= due;
			unique case (tx_st_q)
				TX_IDLE: if (arm_q) begin
					tx_st_q <= TX_WAIT;
				end
				TX_WAIT: if (due) begin
					tx_st_q <= (eff_len == 8'h00) ? TX_IDLE : TX_SEND;
					idx_q <= 8'(HDR_BYTES);
					tx_data_q <= txbuf_q[HDR_BYTES];
				end
				TX_SEND: if (tx_ready) begin
					if (idx_q == last_idx) begin
						tx_st_q <= TX_IDLE;
					end else begin
						idx_q <= idx_q + 8'h01;
						tx_data_q <= txbuf_q[idx_q + 8'h01];
					end
				end
			endcase
		end
	end
	assign tx_start = tx_start_q;
	assign tx_valid = tx_st_q == TX_SEND;
	assign tx_last = tx_valid & (idx_q == last_idx);
	assign tx_data = tx_data_q;
	assign tx_busy = ~tx_idle;
endmodule
`default_nettype wire

// *** gpe_host.sv ***
// Host end: runs register bursts on the serial link and buffers read bytes.
`timescale 1ns/100ps
`default_nettype none
module gpe_host #(
	parameter int HALF = gpe_pkg::SCK_HALF,
	parameter int BW = gpe_pkg::BUF_W,
	parameter int BD = gpe_pkg::BUF_D
) (
	input wire logic ref_clk,
	input wire logic rst,
	gpe_link_if.host link,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic cmd_write,
	input wire logic [6:0] cmd_addr,
	input wire logic [9:0] cmd_count,
	input wire logic wr_valid,
	output logic wr_ready,
	input wire logic [BW-1:0] wr_data,
	output logic rd_valid,
	input wire logic rd_ready,
	output logic [BW-1:0] rd_data,
	output logic busy
);
	import gpe_pkg::*;
	typedef enum logic [4:0] {H_IDLE = 5'b00001, H_GAP = 5'b00010, H_LOW = 5'b00100,
		H_HIGH = 5'b01000, H_END = 5'b10000} gpe_host_state_type;
	localparam int PW = (BD > 1) ? $clog2(BD) : 1;
	gpe_host_state_type st_q;
	logic [7:0] hc_q;
	logic [2:0] bit_q;
	logic [7:0] tx_sh_q;
	logic [7:0] rx_sh_q;
	logic [9:0] rem_q;
	logic wr_q;
	logic is_addr_q;
	logic csn_q;
	logic sck_q;
	logic [1:0] miso_q;
	logic [BW-1:0] mem_q [BD];
	logic [PW-1:0] wp_q;
	logic [PW-1:0] rp_q;
	logic [PW:0] cnt_q;

	wire half_done = hc_q == 8'(HALF - 1);
	wire byte_fin = (st_q == H_HIGH) & half_done & (bit_q == 3'h7);
	wire push = byte_fin & ~is_addr_q & ~wr_q;
	wire pull = rd_valid & rd_ready;
	// A read byte starts only with a free slot, so a stalled reader halts the link clock.
	wire in_ready = cnt_q < (PW + 1)'(BD);
	wire more = (st_q == H_GAP) & (rem_q != 10'h000);
	wire load_wr = more & wr_q & wr_valid;
	wire load_rd = more & ~wr_q & in_ready;
	assign cmd_ready = st_q == H_IDLE;
	assign busy = ~cmd_ready;
	assign wr_ready = more & wr_q;
	assign rd_valid = cnt_q != '0;
	assign rd_data = mem_q[rp_q];
	assign link.csn_n = csn_q;
	assign link.sck = sck_q;
	assign link.mosi = tx_sh_q[7];

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			miso_q <= 2'h0;
		end else begin
			miso_q <= {miso_q[0], link.miso};
		end
	end

	// Sampling at the end of the high phase leaves a full clock period for the far end.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			st_q <= H_IDLE;
			hc_q <= 8'h00;
			bit_q <= 3'h0;
			tx_sh_q <= 8'h00;
			rx_sh_q <= 8'h00;
			rem_q <= 10'h000;
			wr_q <= 1'b0;
			is_addr_q <= 1'b0;
			csn_q <= 1'b1;
			sck_q <= 1'b0;
		end else begin
			unique case (st_q)
				H_IDLE: if (cmd_valid) begin
					csn_q <= 1'b0;
					tx_sh_q <= {cmd_write, cmd_addr};
					rem_q <= cmd_count;
					wr_q <= cmd_write;
					is_addr_q <= 1'b1;
					bit_q <= 3'h0;
					hc_q <= 8'h00;
					st_q <= H_LOW;
				end
				H_LOW: begin
					hc_q <= half_done ? 8'h00 : hc_q + 8'h01;
					if (half_done) begin
						sck_q <= 1'b1;
						st_q <= H_HIGH;
					end
				end
				H_HIGH: begin
					hc_q <= half_done ? 8'h00 : hc_q + 8'h01;
					if (half_done) begin
						sck_q <= 1'b0;
						rx_sh_q <= {rx_sh_q[6:0], miso_q[1]};
						tx_sh_q <= {tx_sh_q[6:0], 1'b0};
						bit_q <= bit_q + 3'h1;
						st_q <= (bit_q == 3'h7) ? H_GAP : H_LOW;
						if (bit_q == 3'h7) begin
							is_addr_q <= 1'b0;
						end
					end
				end
				H_GAP: begin
					if (rem_q == 10'h000) begin
						st_q <= H_END;
					end else if (load_wr || load_rd) begin
						tx_sh_q <= load_wr ? wr_data[7:0] : 8'h00;
						rem_q <= rem_q - 10'h001;
						st_q <= H_LOW;
					end
				end
				H_END: begin
					hc_q <= half_done ? 8'h00 : hc_q + 8'h01;
					if (half_done) begin
						csn_q <= 1'b1;
						if (csn_q) begin
							st_q <= H_IDLE;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				mem_q[wp_q] <= BW'({rx_sh_q[6:0], miso_q[1]});
				wp_q <= (wp_q == PW'(BD - 1)) ? '0 : wp_q + 1'b1;
			end
			if (pull) begin
				rp_q <= (rp_q == PW'(BD - 1)) ? '0 : rp_q + 1'b1;
			end
			cnt_q <= cnt_q + (PW + 1)'(push) - (PW + 1)'(pull);
		end
	end
endmodule
`default_nettype wire

// *** gpe_link_properties.sv ***
// Checker for the link and stream ports of the packet engine pair.
`timescale 1ns/100ps
`default_nettype none
module gpe_link_properties (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic csn_n,
	input wire logic rx_ready,
	input wire logic tx_start,
	input wire logic tx_valid,
	input wire logic tx_ready,
	input wire logic [7:0] tx_data,
	input wire logic tx_busy,
	input wire logic [7:0] tx_payload_len,
	input wire logic [31:0] tx_start_time,
	input wire logic [31:0] timer_us
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	AST_TIMER_STEP: assert property ($changed(timer_us) |->
		timer_us == $past(timer_us) + 32'h1)
		else $error("timer step wrong");
	// A stalled prescaler would freeze every timestamp, so the gap is bounded.
	AST_TIMER_RATE: assert property ($changed(timer_us) |-> ##[1:100] $changed(timer_us))
		else $error("timer too slow");
	AST_TX_MATCH: assert property (tx_start |-> $past(timer_us) == $past(tx_start_time))
		else $error("start off time");
	AST_TRAILER_GAP: assert property ($fell(rx_ready) |-> ##15 !rx_ready ##1 rx_ready)
		else $error("trailer gap wrong");
	AST_START_STREAM: assert property (tx_start && tx_payload_len != 8'h00 |-> tx_valid)
		else $error("no payload at start");
	AST_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
		else $error("payload byte dropped");
	// An empty payload ends the send at the match, so only then may the start find the engine idle.
	AST_BUSY_SEND: assert property (tx_start |->
		$past(tx_busy) && (tx_busy || tx_payload_len == 8'h00))
		else $error("start while idle");
	AST_CSN_GAP: assert property ($rose(csn_n) |-> csn_n [*4])
		else $error("frame gap short");
endmodule
`default_nettype wire

// *** gateway_packet_engine_bench.sv ***
// Bench joining host and device ends of the packet engine link.
`timescale 1ns/100ps
`default_nettype none
module gateway_packet_engine_bench;
	import gpe_pkg::*;
	logic ref_clk, rst, cmd_valid, cmd_ready, cmd_write, wr_valid, wr_ready, rd_valid, rd_ready;
	logic busy, rx_valid, rx_ready, rx_last, rx_crc_en, tx_start, tx_valid, tx_ready, tx_last;
	logic tx_busy, tx_radio_b, tx_fsk, tx_power_high, tx_crc_en, tx_implicit_hdr, tx_var_len;
	logic tx_fsk_crc_en, tx_check_polynomial_select;
	logic [6:0] cmd_addr;
	logic [9:0] cmd_count;
	logic [7:0] wr_data, rd_data, rx_data, rx_channel, rx_snr_avg, rx_snr_min, rx_snr_max, rx_rssi;
	logic [7:0] rx_demod_unit_index, rx_detect_corr_quality, tx_data, tx_payload_len, tx_freq_dev;
	logic [3:0] rx_spreading_factor, tx_spreading_factor;
	logic [2:0] rx_coding_rate_code, tx_coding_rate_code;
	logic [15:0] rx_crc_value, rx_corr_peak_position, tx_preamble_len, tx_bitrate_div;
	logic [1:0] tx_bandwidth, tx_dc_free;
	logic [23:0] tx_freq_code;
	logic [31:0] tx_start_time, timer_us;
	logic [7:0] bt [0:255];
	int n_mismatch, check_count, cyc, tsx, st, k;
	gpe_link_if link ();
	gpe_host gpe_host_i (.ref_clk, .rst, .link(link), .cmd_valid, .cmd_ready, .cmd_write, .cmd_addr,
		.cmd_count, .wr_valid, .wr_ready, .wr_data, .rd_valid, .rd_ready, .rd_data, .busy);
	gpe_device gpe_device_i (.ref_clk, .rst, .link(link), .rx_valid, .rx_ready, .rx_data, .rx_last,
		.rx_channel, .rx_spreading_factor, .rx_coding_rate_code, .rx_crc_en, .rx_snr_avg, .rx_snr_min,
		.rx_snr_max, .rx_rssi, .rx_crc_value, .rx_demod_unit_index, .rx_corr_peak_position,
		.rx_detect_corr_quality, .tx_start, .tx_valid, .tx_ready, .tx_data, .tx_last, .tx_busy,
		.tx_freq_code, .tx_start_time, .tx_radio_b, .tx_fsk, .tx_power_high, .tx_crc_en,
		.tx_coding_rate_code, .tx_spreading_factor, .tx_payload_len, .tx_implicit_hdr,
		.tx_bandwidth, .tx_preamble_len, .tx_freq_dev, .tx_var_len, .tx_fsk_crc_en, .tx_dc_free,
		.tx_check_polynomial_select, .tx_bitrate_div, .timer_us);
	gpe_link_properties gpe_link_properties_i (.ref_clk, .rst, .csn_n(link.csn_n), .rx_ready,
		.tx_start, .tx_valid, .tx_ready, .tx_data, .tx_busy, .tx_payload_len, .tx_start_time,
		.timer_us);
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask
	task automatic test_done;
		$display("checks %0d, mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic step;
		@(posedge ref_clk);
		#1;
	endtask
	// Read bytes are taken with rd_ready toggling, so the host buffer fills and the link stalls.
	task automatic xfer(input logic w, input logic [6:0] a, input int n);
		int i;
		int t;
		i = 0;
		t = 0;
		cmd_valid = 1'b1;
		cmd_write = w;
		cmd_addr = a;
		cmd_count = n[9:0];
		wr_valid = w;
		wr_data = bt[0];
		@(negedge ref_clk);
		while (cmd_ready !== 1'b1) @(negedge ref_clk);
		step();
		cmd_valid = 1'b0;
		while (i < n) begin
			@(negedge ref_clk);
			if (w && wr_ready === 1'b1) i++;
			if (!w && rd_valid === 1'b1 && rd_ready === 1'b1) begin
				bt[i] = rd_data;
				i++;
			end
			step();
			wr_data = bt[i];
			t++;
			rd_ready = t[7];
		end
		wr_valid = 1'b0;
		rd_ready = 1'b1;
		@(negedge ref_clk);
		while (busy !== 1'b0) @(negedge ref_clk);
		step();
	endtask
	task automatic wr1(input logic [6:0] a, input logic [7:0] v);
		bt[0] = v;
		xfer(1'b1, a, 1);
	endtask
	task automatic load(input logic [127:0] h);
		for (int j = 0; j < 16; j++) bt[j] = h[127-8*j -: 8];
	endtask
	task automatic meta(input logic [7:0] b);
		rx_channel = b;
		{rx_spreading_factor, rx_coding_rate_code, rx_crc_en} = b + 8'h01;
		rx_snr_avg = b + 8'h02;
		rx_snr_min = b + 8'h03;
		rx_snr_max = b + 8'h04;
		rx_rssi = b + 8'h05;
		rx_crc_value = {b + 8'h0B, b + 8'h0A};
		rx_demod_unit_index = b + 8'h0C;
		rx_corr_peak_position = {b + 8'h0E, b + 8'h0D};
		rx_detect_corr_quality = b + 8'h0F;
	endtask
	task automatic pkt(input int len, input logic [7:0] b);
		int i;
		i = 0;
		meta(b);
		rx_valid = 1'b1;
		while (i < len) begin
			rx_data = b + 8'h40 + i[7:0];
			rx_last = (i == len - 1);
			@(negedge ref_clk);
			if (rx_ready === 1'b1) begin
				i++;
				tsx = cyc / 100;
			end
			step();
		end
		rx_valid = 1'b0;
		rx_last = 1'b0;
		repeat (20) step();
	endtask
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) cyc <= rst ? 0 : cyc + 1;
	initial begin
		repeat (40000) @(posedge ref_clk);
		n_mismatch++;
		test_done();
	end
	initial begin
		rst = 1'b1;
		{cmd_valid, cmd_write, cmd_addr, cmd_count, wr_valid, wr_data} = '0;
		{rx_valid, rx_data, rx_last, tx_ready} = '0;
		rd_ready = 1'b1;
		meta(8'h00);
		repeat (6) @(posedge ref_clk);
		#1;
		rst = 1'b0;
		step();
		pkt(5, 8'h03);
		xfer(1'b0, A_PKT_COUNT, 1);
		chk(bt[0], 8'h01);
		wr1(A_FIFO_CTRL, 8'h01);
		xfer(1'b0, A_PKT_COUNT, 4);
		chk(bt[0], 8'h00);
		chk({bt[2], bt[1], bt[3]}, 24'h000005);
		bt[0] = bt[1];
		bt[1] = bt[2];
		xfer(1'b1, A_PTR_LO, 2);
		xfer(1'b0, A_PKT_DATA, 21);
		for (k = 0; k < 5; k++) chk(bt[k], 8'h43 + k[7:0]);
		for (k = 0; k < 16; k++) if (k < 6 || k > 9) chk(bt[5 + k], 8'h03 + k[7:0]);
		chk({bt[14], bt[13], bt[12], bt[11]} + 32'h1 - tsx <= 32'h2, 1'h1);
		xfer(1'b0, A_PTR_LO, 2);
		chk({bt[1], bt[0]}, 16'h0015);
		xfer(1'b0, 7'h7F, 1);
		chk(bt[0], 8'h00);
		wr1(A_FIFO_CTRL, 8'h01);
		for (k = 0; k < 17; k++) pkt(1, 8'h01 + k[7:0]);
		xfer(1'b0, A_PKT_COUNT, 1);
		chk(bt[0], 8'h10);
		wr1(A_FIFO_CTRL, 8'h01);
		xfer(1'b0, A_PKT_COUNT, 4);
		chk({bt[0], bt[2], bt[1], bt[3]}, 32'h0F001501);
		bt[0] = bt[1];
		bt[1] = bt[2];
		xfer(1'b1, A_PTR_LO, 2);
		xfer(1'b0, A_PKT_DATA, 17);
		chk({bt[0], bt[1], bt[16]}, 24'h410110);
		wr1(A_TX_PTR, 8'h00);
		st = cyc / 100 + 40;
		load({24'h123456, st[31:0], 72'h2800D9030601020000});
		{bt[16], bt[17], bt[18]} = 24'hC1C2C3;
		xfer(1'b1, A_TX_DATA, 19);
		chk(tx_freq_code, 24'h123456);
		chk(tx_start_time, st);
		chk({tx_radio_b, tx_fsk, tx_power_high}, 3'h5);
		chk({tx_crc_en, tx_coding_rate_code, tx_spreading_factor}, 8'hD9);
		chk({tx_payload_len, tx_implicit_hdr, tx_bandwidth, tx_preamble_len}, 27'h1E0102);
		wr1(A_TX_CTRL, 8'h01);
		xfer(1'b0, A_TX_CTRL, 2);
		chk({tx_busy, bt[0], bt[1]}, 17'h10113);
		k = 0;
		while (tx_start !== 1'b1 && k < 8000) begin
			@(negedge ref_clk);
			k++;
		end
		chk(timer_us, st);
		k = 0;
		while (k < 3) begin
			@(negedge ref_clk);
			if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
				chk({tx_data, tx_last}, {8'hC1 + k[7:0], k == 2});
				k++;
			end
			step();
			tx_ready = ~tx_ready;
		end
		repeat (4) step();
		chk(tx_busy, 1'h0);
		wr1(A_TX_PTR, 8'h00);
		load(128'h65432100000000170019041B000801F4);
		xfer(1'b1, A_TX_DATA, 16);
		chk(tx_freq_code, 24'h654321);
		chk({tx_radio_b, tx_fsk, tx_power_high, tx_spreading_factor}, 7'h20);
		chk({tx_freq_dev, tx_payload_len}, 16'h1904);
		chk({tx_check_polynomial_select, tx_dc_free, tx_fsk_crc_en, tx_var_len}, 5'h1B);
		chk({tx_preamble_len, tx_bitrate_div}, 32'h000801F4);
		for (k = 0; k < 4; k++) begin
			wr1(A_TX_PTR, 8'h0B);
			wr1(A_TX_DATA, {4'h1, k[1:0], 2'h3});
			chk(tx_dc_free, k[1:0]);
		end
		test_done();
	end
endmodule
`default_nettype wire
